// File: bench/evcfg_host_mdl.sv
// Host side model: pull-up on the event line and alert response pulses.
// Assumes the device drives the line open drain from core_clk.
`timescale 1ns/100ps
module evcfg_host_mdl (
  // Clock
  input wire logic core_clk,
  // Device pin
  input wire logic event_out,
  input wire logic event_oe_n,
  // Host side
  input wire logic ara_go,
  output logic alert_response,
  output logic pin_level
);
  // Pull-up wins when released
  assign pin_level = event_oe_n ? 1'b1 : event_out;
  logic ara_q = 1'b0;
  always @(posedge core_clk) begin
    ara_q <= #1 ara_go;
  end
  assign alert_response = ara_q;
endmodule : evcfg_host_mdl

// File: bench/tb.sv
// Testbench for the event output control bits and the event pin.
// Assumes the host model resolves the open drain line.
`timescale 1ns/100ps
module tb;
  import evcfg_pkg::*;
  logic core_clk = 1'b0, arst_n = 1'b0, cfg_wr = 1'b0, crit_lock = 1'b0, alarm_lock = 1'b0;
  logic shutdown = 1'b0, shutdown_alert_hold_select = 1'b0, bus_timeout_disable = 1'b0;
  logic data_pin_enable = 1'b1, conv_done = 1'b0, above_window = 1'b0, above_crit = 1'b0;
  logic clear_pending_alert = 1'b0, ara_go = 1'b0;
  logic alert_response, event_out, event_oe_n, event_status, pin_level;
  logic [EVCFG_CFG_W-1:0] cfg_wdata = 16'h0000;
  logic [EVCFG_CFG_W-1:0] cfg_rdata;
  int num_errors = 0;
  int tests_run = 0;
  int cyc = 0;

  evcfg_top uut (.core_clk(core_clk), .arst_n(arst_n), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .crit_lock(crit_lock), .alarm_lock(alarm_lock), .shutdown(shutdown),
    .shutdown_alert_hold_select(shutdown_alert_hold_select),
    .bus_timeout_disable(bus_timeout_disable), .data_pin_enable(data_pin_enable),
    .conv_done(conv_done), .above_window(above_window), .above_crit(above_crit),
    .clear_pending_alert(clear_pending_alert), .alert_response(alert_response),
    .event_out(event_out), .event_oe_n(event_oe_n), .event_status(event_status));
  evcfg_host_mdl host (.core_clk(core_clk), .event_out(event_out), .event_oe_n(event_oe_n),
    .ara_go(ara_go), .alert_response(alert_response), .pin_level(pin_level));

  initial begin
    forever #5 core_clk = ~core_clk;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      num_errors++;
      end_sim();
    end
  end

  task automatic stp(input int n);
    repeat (n) @(negedge core_clk);
  endtask : stp
  task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
    tests_run++;
    if (got !== ex) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  task automatic pin(input string nm, input logic ex);
    chk(nm, {15'h0000, ex}, {15'h0000, pin_level});
  endtask : pin
  task automatic wr(input logic [15:0] d);
    cfg_wr = 1'b1;
    cfg_wdata = d;
    stp(1);
    cfg_wr = 1'b0;
    stp(3);
  endtask : wr
  task automatic conv();
    conv_done = 1'b1;
    stp(1);
    conv_done = 1'b0;
    stp(3);
  endtask : conv
  task automatic cond(input logic w, input logic c);
    above_window = w;
    above_crit = c;
    stp(3);
  endtask : cond
  task automatic pulse_clear();
    clear_pending_alert = 1'b1;
    stp(1);
    clear_pending_alert = 1'b0;
    stp(3);
  endtask : pulse_clear
  task automatic done(input string nm);
    $display("test %s finished", nm);
  endtask : done

  initial begin
    stp(5);
    arst_n = 1'b1;
    stp(1);
    chk("rdata reset", 16'h0000, cfg_rdata);
    cond(1'b1, 1'b0);
    pin("pin disabled", 1'b1);
    chk("status disabled", 16'h0000, {15'h0000, event_status});
    cond(1'b0, 1'b0);
    done("reset");
    wr(16'h0008);
    conv();
    chk("rdata enable", 16'h0008, cfg_rdata);
    cond(1'b1, 1'b0);
    pin("cmp set", 1'b0);
    chk("status set", 16'h0001, {15'h0000, event_status});
    cond(1'b0, 1'b0);
    pin("cmp clear", 1'b1);
    chk("status clear", 16'h0000, {15'h0000, event_status});
    done("comparator");
    wr(16'h000c);
    conv();
    cond(1'b1, 1'b0);
    pin("cvo window", 1'b1);
    cond(1'b1, 1'b1);
    pin("cvo crit", 1'b0);
    cond(1'b0, 1'b0);
    done("critical only");
    wr(16'h0009);
    cond(1'b1, 1'b1);
    cond(1'b0, 1'b0);
    pin("mode before conv", 1'b1);
    conv();
    cond(1'b1, 1'b0);
    cond(1'b0, 1'b0);
    pin("int latched", 1'b0);
    chk("status latched", 16'h0001, {15'h0000, event_status});
    pulse_clear();
    pin("int cleared", 1'b1);
    cond(1'b1, 1'b0);
    cond(1'b0, 1'b0);
    pin("int relatched", 1'b0);
    ara_go = 1'b1;
    stp(1);
    ara_go = 1'b0;
    stp(4);
    pin("ara cleared", 1'b1);
    done("interrupt");
    wr(16'h000b);
    pin("pol high", 1'b0);
    shutdown = 1'b1;
    stp(2);
    wr(16'h0009);
    pin("pol in shutdown", 1'b1);
    bus_timeout_disable = 1'b1;
    wr(16'h000b);
    pin("pol deferred", 1'b1);
    shutdown = 1'b0;
    stp(3);
    pin("pol applied", 1'b0);
    bus_timeout_disable = 1'b0;
    data_pin_enable = 1'b0;
    shutdown = 1'b1;
    wr(16'h0009);
    pin("pol deferred no data pin", 1'b0);
    shutdown = 1'b0;
    data_pin_enable = 1'b1;
    stp(3);
    pin("pol applied data pin", 1'b1);
    done("polarity");
    wr(16'h0008);
    conv();
    cond(1'b1, 1'b0);
    shutdown = 1'b1;
    stp(2);
    cond(1'b0, 1'b0);
    pin("frozen", 1'b0);
    shutdown_alert_hold_select = 1'b1;
    stp(3);
    pin("sleep released", 1'b1);
    shutdown = 1'b0;
    shutdown_alert_hold_select = 1'b0;
    stp(3);
    done("shutdown");
    crit_lock = 1'b1;
    wr(16'h0007);
    chk("crit lock", 16'h000c, cfg_rdata);
    alarm_lock = 1'b1;
    wr(16'h0000);
    chk("both locks", 16'h000c, cfg_rdata);
    crit_lock = 1'b0;
    wr(16'h0002);
    chk("alarm lock", 16'h000c, cfg_rdata);
    alarm_lock = 1'b0;
    wr(16'h0000);
    chk("unlocked", 16'h0000, cfg_rdata);
    done("locks");
    end_sim();
  end
endmodule : tb

// File: logic/evcfg_gen.sv
// Event state generator: comparator or latched interrupt behaviour.
// Assumes threshold conditions are already synchronous to core_clk.
`timescale 1ns/100ps
module evcfg_gen (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Settings and conditions
  evcfg_if.gen ev
);
  import evcfg_pkg::*;

  logic cond;
  logic rise;
  logic cond_q, cond_d;
  logic pend_q, pend_d;
  logic asserted_q, asserted_d;

  // [R2] Critical-only selection
  assign cond = ev.crit_only ? ev.above_crit : (ev.above_window | ev.above_crit);
  assign rise = cond & ~cond_q & ~ev.shut_freeze & ~ev.shut_idle;

  always_comb begin
    cond_d = cond;
    // [R11] Clear, set wins
    pend_d = (rise & ev.int_mode) | (pend_q & ~ev.clear);
    // [R6] Shutdown freeze or idle
    if (ev.shut_idle) begin
      asserted_d = 1'b0;
    end else if (ev.shut_freeze) begin
      asserted_d = asserted_q;
    // [R12] Interrupt latches, comparator follows
    end else if (ev.int_mode) begin
      asserted_d = pend_d;
    end else begin
      asserted_d = cond;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cond_q <= 1'b0;
      pend_q <= 1'b0;
      asserted_q <= 1'b0;
    end else begin
      cond_q <= cond_d;
      pend_q <= pend_d;
      asserted_q <= asserted_d;
    end
  end

  assign ev.asserted = asserted_q;

  property p_idle_off;
    @(posedge core_clk) disable iff (!arst_n)
    ev.shut_idle |=> !asserted_q;
  endproperty
  a_idle_off: assert property (p_idle_off) else $error("event asserted in idle shutdown"); // [R6]

  property p_freeze;
    @(posedge core_clk) disable iff (!arst_n)
    ev.shut_freeze |=> asserted_q == $past(asserted_q);
  endproperty
  a_freeze: assert property (p_freeze) else $error("event moved while frozen"); // [R6]

  property p_clear;
    @(posedge core_clk) disable iff (!arst_n)
    (ev.clear && !rise) |=> !pend_q;
  endproperty
  a_clear: assert property (p_clear) else $error("pending event not cleared"); // [R11]

  property p_comparator;
    @(posedge core_clk) disable iff (!arst_n)
    (!ev.int_mode && !ev.shut_freeze && !ev.shut_idle) |=> asserted_q == $past(cond);
  endproperty
  a_comparator: assert property (p_comparator) else $error("comparator not following"); // [R12]

  property p_crit_only;
    @(posedge core_clk) disable iff (!arst_n)
    (ev.crit_only && !ev.above_crit && !ev.int_mode && !ev.shut_freeze && !ev.shut_idle)
      |=> !asserted_q;
  endproperty
  a_crit_only: assert property (p_crit_only) else $error("non-critical event passed"); // [R2]

  property p_latch;
    @(posedge core_clk) disable iff (!arst_n)
    (ev.int_mode && rise) |=> asserted_q;
  endproperty
  a_latch: assert property (p_latch) else $error("interrupt not latched"); // [R12]
endmodule : evcfg_gen

// File: logic/evcfg_if.sv
// Carries the effective event settings to the event state generator.
// Assumes both ends run on the same core clock.
`timescale 1ns/100ps
interface evcfg_if;
  logic above_window;
  logic above_crit;
  logic crit_only;
  logic int_mode;
  logic clear;
  logic shut_freeze;
  logic shut_idle;
  logic asserted;
  modport ctl (
    output above_window, above_crit, crit_only, int_mode, clear, shut_freeze, shut_idle,
    input asserted
  );
  modport gen (
    input above_window, above_crit, crit_only, int_mode, clear, shut_freeze, shut_idle,
    output asserted
  );
endinterface : evcfg_if

// File: logic/evcfg_pkg.sv
// Constants for the event output control bits of the sensor configuration.
// Assumes a 16-bit configuration word supplied by the serial protocol engine.
package evcfg_pkg;
  localparam int unsigned EVCFG_CFG_W = 16;
  localparam int unsigned EVCFG_BIT_MODE = 0;
  localparam int unsigned EVCFG_BIT_POL = 1;
  localparam int unsigned EVCFG_BIT_CVO = 2;
  localparam int unsigned EVCFG_BIT_EN = 3;
  localparam logic EVCFG_RST_MODE = 1'b0;
  localparam logic EVCFG_RST_POL = 1'b0;
  localparam logic EVCFG_RST_CVO = 1'b0;
  localparam logic EVCFG_RST_EN = 1'b0;
  localparam logic [15:0] EVCFG_RD_ZERO = 16'h0000;
endpackage : evcfg_pkg

// File: logic/evcfg_top.sv
// Event output control bits of the sensor configuration and the event pin.
// Assumes writes, lock bits, shutdown and conditions come from core logic.
// Operation
// [R1] Either lock set: writes to output enable and mode bits are ignored.
// [R2] Critical-only bit 2: 0 alarm or critical events, 1 critical only.
// [R3] Alarm-window lock set: critical-only bit writes are ignored.
// [R4] Polarity bit 1: 0 active low, 1 active high; locked by either lock.
// [R5] Polarity change moves the pin at once, even during shutdown.
// [R6] Shutdown: hold select 0 freezes event, 1 drives it de-asserted.
// [R7] Other bit changes apply after a conversion completes outside shutdown.
// [R8] Shutdown with timeout disabled, or data pin disabled: polarity deferred.
// [R9] Mode bit 0: 0 comparator, 1 interrupt.
// [R10] Output enable bit 3: 0 keeps the pin released, 1 allows drive.
// [R11] Clear bit or alert response clears a pending interrupt event.
// [R12] Comparator follows condition; interrupt stays asserted until cleared.
`timescale 1ns/100ps
module evcfg_top (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Configuration write and read
  input wire logic cfg_wr,
  input wire logic [evcfg_pkg::EVCFG_CFG_W-1:0] cfg_wdata,
  output logic [evcfg_pkg::EVCFG_CFG_W-1:0] cfg_rdata,
  // Lock bits
  input wire logic crit_lock,
  input wire logic alarm_lock,
  // Shutdown and bus settings
  input wire logic shutdown,
  input wire logic shutdown_alert_hold_select,
  input wire logic bus_timeout_disable,
  input wire logic data_pin_enable,
  input wire logic conv_done,
  // Threshold conditions
  input wire logic above_window,
  input wire logic above_crit,
  // Event clearing
  input wire logic clear_pending_alert,
  input wire logic alert_response,
  // Event pin, open drain
  output logic event_out,
  output logic event_oe_n,
  output logic event_status
);
  import evcfg_pkg::*;

  evcfg_if ev ();

  logic lock_any;
  logic pol_defer;
  logic pin_level;
  logic sh_mode_q, sh_mode_d;
  logic sh_pol_q, sh_pol_d;
  logic sh_cvo_q, sh_cvo_d;
  logic sh_en_q, sh_en_d;
  logic act_mode_q, act_mode_d;
  logic act_pol_q, act_pol_d;
  logic act_cvo_q, act_cvo_d;
  logic act_en_q, act_en_d;
  logic oe_n_q, oe_n_d;
  logic stat_q, stat_d;
  logic [EVCFG_CFG_W-1:0] rd_q, rd_d;

  assign lock_any = crit_lock | alarm_lock;
  // [R8] Polarity deferral in shutdown
  assign pol_defer = shutdown & (bus_timeout_disable | ~data_pin_enable);

  // Written copy of the bits
  always_comb begin
    sh_mode_d = sh_mode_q;
    sh_pol_d = sh_pol_q;
    sh_cvo_d = sh_cvo_q;
    sh_en_d = sh_en_q;
    if (cfg_wr) begin
      // [R1] Enable and mode locked
      if (!lock_any) begin
        sh_en_d = cfg_wdata[EVCFG_BIT_EN];
        sh_mode_d = cfg_wdata[EVCFG_BIT_MODE];
      end
      // [R4] Polarity locked
      if (!lock_any) begin
        sh_pol_d = cfg_wdata[EVCFG_BIT_POL];
      end
      // [R3] Critical-only locked
      if (!alarm_lock) begin
        sh_cvo_d = cfg_wdata[EVCFG_BIT_CVO];
      end
    end
  end

  // Effective copy used by the event logic
  always_comb begin
    act_mode_d = act_mode_q;
    act_cvo_d = act_cvo_q;
    act_en_d = act_en_q;
    // [R7] Apply on conversion outside shutdown
    if (conv_done && !shutdown) begin
      act_mode_d = sh_mode_q;
      act_cvo_d = sh_cvo_q;
      act_en_d = sh_en_q;
    end
    // [R5] Polarity follows at once
    act_pol_d = pol_defer ? act_pol_q : sh_pol_q;
  end

  // Pin drive and readback
  always_comb begin
    // [R4] Level from polarity
    pin_level = act_pol_q ? ev.asserted : ~ev.asserted;
    // [R10] Released unless enabled
    oe_n_d = ~(act_en_q & ~pin_level);
    stat_d = act_en_q & ev.asserted;
    rd_d = EVCFG_RD_ZERO;
    rd_d[EVCFG_BIT_MODE] = sh_mode_q;
    rd_d[EVCFG_BIT_POL] = sh_pol_q;
    rd_d[EVCFG_BIT_CVO] = sh_cvo_q;
    rd_d[EVCFG_BIT_EN] = sh_en_q;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sh_mode_q <= EVCFG_RST_MODE;
      sh_pol_q <= EVCFG_RST_POL;
      sh_cvo_q <= EVCFG_RST_CVO;
      sh_en_q <= EVCFG_RST_EN;
      act_mode_q <= EVCFG_RST_MODE;
      act_pol_q <= EVCFG_RST_POL;
      act_cvo_q <= EVCFG_RST_CVO;
      act_en_q <= EVCFG_RST_EN;
      oe_n_q <= 1'b1;
      stat_q <= 1'b0;
      rd_q <= EVCFG_RD_ZERO;
    end else begin
      sh_mode_q <= sh_mode_d;
      sh_pol_q <= sh_pol_d;
      sh_cvo_q <= sh_cvo_d;
      sh_en_q <= sh_en_d;
      act_mode_q <= act_mode_d;
      act_pol_q <= act_pol_d;
      act_cvo_q <= act_cvo_d;
      act_en_q <= act_en_d;
      oe_n_q <= oe_n_d;
      stat_q <= stat_d;
      rd_q <= rd_d;
    end
  end

  // Open drain only ever pulls low
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      event_out <= 1'b0;
    end else begin
      event_out <= 1'b0;
    end
  end

  // [R2] Settings to the generator
  assign ev.crit_only = act_cvo_q;
  // [R9] Mode selection
  assign ev.int_mode = act_mode_q;
  assign ev.above_window = above_window;
  assign ev.above_crit = above_crit;
  // [R11] Clear sources
  assign ev.clear = clear_pending_alert | alert_response;
  // [R6] Shutdown behaviour select
  assign ev.shut_freeze = shutdown & ~shutdown_alert_hold_select;
  assign ev.shut_idle = shutdown & shutdown_alert_hold_select;

  evcfg_gen u_gen (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .ev(ev)
  );

  assign event_oe_n = oe_n_q;
  assign event_status = stat_q;
  assign cfg_rdata = rd_q;

  property p_lock_en_mode;
    @(posedge core_clk) disable iff (!arst_n)
    (cfg_wr && lock_any) |=> (sh_en_q == $past(sh_en_q)) && (sh_mode_q == $past(sh_mode_q));
  endproperty
  a_lock_en_mode: assert property (p_lock_en_mode) else $error("locked bit changed"); // [R1]

  property p_lock_cvo;
    @(posedge core_clk) disable iff (!arst_n)
    (cfg_wr && alarm_lock) |=> sh_cvo_q == $past(sh_cvo_q);
  endproperty
  a_lock_cvo: assert property (p_lock_cvo) else $error("critical-only changed under lock"); // [R3]

  property p_lock_pol;
    @(posedge core_clk) disable iff (!arst_n)
    (cfg_wr && lock_any) |=> sh_pol_q == $past(sh_pol_q);
  endproperty
  a_lock_pol: assert property (p_lock_pol) else $error("polarity changed under lock"); // [R4]

  property p_write_ok;
    @(posedge core_clk) disable iff (!arst_n)
    (cfg_wr && !lock_any) |=> sh_pol_q == $past(cfg_wdata[EVCFG_BIT_POL]) ##1
      rd_q[EVCFG_BIT_POL] == $past(sh_pol_q);
  endproperty
  a_write_ok: assert property (p_write_ok) else $error("polarity write lost"); // [R4]

  property p_pol_now;
    @(posedge core_clk) disable iff (!arst_n)
    (sh_pol_q != act_pol_q && !pol_defer) |=> act_pol_q == $past(sh_pol_q);
  endproperty
  a_pol_now: assert property (p_pol_now) else $error("polarity change delayed"); // [R5]

  property p_pol_defer;
    @(posedge core_clk) disable iff (!arst_n)
    pol_defer |=> act_pol_q == $past(act_pol_q);
  endproperty
  a_pol_defer: assert property (p_pol_defer) else $error("polarity not deferred"); // [R8]

  property p_hold_shutdown;
    @(posedge core_clk) disable iff (!arst_n)
    shutdown |=> (act_mode_q == $past(act_mode_q)) && (act_en_q == $past(act_en_q))
      && (act_cvo_q == $past(act_cvo_q));
  endproperty
  a_hold_shutdown: assert property (p_hold_shutdown) else $error("applied bit moved"); // [R7]

  property p_disabled;
    @(posedge core_clk) disable iff (!arst_n)
    !act_en_q |=> event_oe_n;
  endproperty
  a_disabled: assert property (p_disabled) else $error("pin driven while disabled"); // [R10]

  property p_mode_apply;
    @(posedge core_clk) disable iff (!arst_n)
    (conv_done && !shutdown) |=> act_mode_q == $past(sh_mode_q);
  endproperty
  a_mode_apply: assert property (p_mode_apply) else $error("mode not applied"); // [R9]
endmodule : evcfg_top
